// >>> logic/opdec_top.sv
// Purpose: Operand field decoder for the 8-bit core.
// Assumes: Fields are synchronous to clk_i, answers one cycle later.
//   The opcode decode sets pair_kind_i for the pair field in use.
// Notes: All outputs registered.
//   Flag bits: carry 0, zero 1, parity/overflow 2, sign 7.
// Operation
// RQ1: Byte field 000..101 picks B,C,D,E,pair high,pair low; 111 the acc.
// RQ2: General pair field 00,01,10,11 picks pair zero, one, pointer, stack.
// RQ3: Indexed pair fields swap code 10 for the first or second index reg.
// RQ4: Stack op pair field code 11 picks the accumulator flags pair.
// RQ5: Half select routes bits 15..8 for high and 7..0 for low.
// RQ6: Bit field is a straight binary bit index 0 to 7.
// RQ7: Condition 000/001 tests zero clear/set, 010/011 carry clear/set.
// RQ8: Condition 100/101 tests parity odd/even, 110/111 sign plus/minus.
// RQ9: Restart field times eight gives the page zero call target.
// RQ10: Byte field 110 selects no register and flags a memory operand.
`timescale 1ns/100ps
`include "opdec_defs.svh"
module opdec_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] byte_code_i,
  input wire logic [1:0] pair_code_i,
  input wire opdec_pkg::opdec_kind_t pair_kind_i,
  input wire logic [15:0] pair_value_i,
  input wire logic half_high_i,
  input wire logic [2:0] bit_code_i,
  input wire logic [2:0] cond_code_i,
  input wire logic [7:0] flags_i,
  input wire logic [2:0] rst_code_i,
  output opdec_pkg::opdec_breg_t byte_sel_o,
  output logic byte_mem_o,
  output opdec_pkg::opdec_pair_t pair_sel_o,
  output logic [7:0] pair_half_o,
  output logic [7:0] bit_mask_o,
  output logic cond_true_o,
  output logic [7:0] rst_addr_o
);
  opdec_if pif ();

  assign pif.code = pair_code_i;
  assign pif.kind = pair_kind_i;

  opdec_pair u_pair (
    .pif(pif.decoder)
  );

  // Flag byte bit tested by each pair of condition codes
  function automatic logic flag_pick(input logic [1:0] group,
                                     input logic [7:0] fl);
    logic bitv;
    bitv = 1'b0;
    case (group)
      2'h0: bitv = fl[`OPDEC_FLAG_Z];
      2'h1: bitv = fl[`OPDEC_FLAG_C];
      2'h2: bitv = fl[`OPDEC_FLAG_PV];
      default: bitv = fl[`OPDEC_FLAG_S];
    endcase
    return bitv;
  endfunction : flag_pick

  // Even code branches on a clear flag, odd on a set one
  function automatic logic cond_eval(input logic [2:0] f,
                                     input logic [7:0] fl);
    logic hit;
    hit = 1'b0;
    case (f)
      // RQ7 zero and carry
      3'h0: hit = ~flag_pick(2'h0, fl);
      3'h1: hit = flag_pick(2'h0, fl);
      3'h2: hit = ~flag_pick(2'h1, fl);
      3'h3: hit = flag_pick(2'h1, fl);
      // RQ8 parity and sign
      3'h4: hit = ~flag_pick(2'h2, fl);
      3'h5: hit = flag_pick(2'h2, fl);
      3'h6: hit = ~flag_pick(2'h3, fl);
      3'h7: hit = flag_pick(2'h3, fl);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : cond_eval

  // Byte field to register select; code 110 names no register
  function automatic opdec_pkg::opdec_breg_t byte_decode(
      input logic [2:0] code);
    opdec_pkg::opdec_breg_t sel;
    sel = opdec_pkg::OPDEC_BREG_NONE;
    case (code)
      3'h0: sel = opdec_pkg::OPDEC_BREG_B;
      3'h1: sel = opdec_pkg::OPDEC_BREG_C;
      3'h2: sel = opdec_pkg::OPDEC_BREG_D;
      3'h3: sel = opdec_pkg::OPDEC_BREG_E;
      3'h4: sel = opdec_pkg::OPDEC_BREG_PH;
      3'h5: sel = opdec_pkg::OPDEC_BREG_PL;
      `OPDEC_G_CODE_MEM: sel = opdec_pkg::OPDEC_BREG_NONE;
      3'h7: sel = opdec_pkg::OPDEC_BREG_ACC;
      default: sel = opdec_pkg::OPDEC_BREG_NONE;
    endcase
    return sel;
  endfunction : byte_decode

  // Memory operand when the byte field selects no register
  function automatic logic byte_is_mem(input logic [2:0] code);
    return byte_decode(code) == opdec_pkg::OPDEC_BREG_NONE;
  endfunction : byte_is_mem

  // Upper byte for the high half, lower byte otherwise
  function automatic logic [7:0] half_pick(input logic [15:0] value,
                                           input logic high);
    logic [7:0] half;
    half = value[`OPDEC_LO_MSB:`OPDEC_LO_LSB];
    if (high) begin
      half = value[`OPDEC_HI_MSB:`OPDEC_HI_LSB];
    end
    return half;
  endfunction : half_pick

  // Slot times eight; the top two bits stay zero for page zero
  function automatic logic [7:0] rst_target(input logic [2:0] slot);
    logic [7:0] target;
    target = {5'h00, slot};
    return target << `OPDEC_RST_SHIFT;
  endfunction : rst_target

  // One-hot position test for the bit index field
  function automatic logic mask_bit(input logic [2:0] code,
                                    input int idx);
    return code == 3'(idx);
  endfunction : mask_bit

  // Next values of the output flops
  opdec_pkg::opdec_breg_t byte_sel_nxt;
  logic byte_mem_nxt;
  opdec_pkg::opdec_pair_t pair_sel_nxt;
  logic [7:0] pair_half_nxt;
  logic [7:0] bit_mask_nxt;
  logic cond_true_nxt;
  logic [7:0] rst_addr_nxt;

  // RQ1 byte register decode
  assign byte_sel_nxt = byte_decode(byte_code_i);
  // RQ10 memory operand decode
  assign byte_mem_nxt = byte_is_mem(byte_code_i);
  // RQ2 pair lookup answer
  assign pair_sel_nxt = pif.pair;
  // RQ5 half routing
  assign pair_half_nxt = half_pick(pair_value_i, half_high_i);
  // RQ7 RQ8 condition test
  assign cond_true_nxt = cond_eval(cond_code_i, flags_i);
  // RQ9 restart target
  assign rst_addr_nxt = rst_target(rst_code_i);

  // RQ6 one-hot bit index
  for (genvar gi = 0; gi < 8; gi++) begin : g_mask
    assign bit_mask_nxt[gi] = mask_bit(bit_code_i, gi);
  end

  // Output flops; every answer lags its fields by one edge
  // RQ1 byte register select
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      byte_sel_o <= opdec_pkg::OPDEC_BREG_B;
    end else begin
      byte_sel_o <= byte_sel_nxt;
    end
  end

  // RQ10 memory operand flag
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      byte_mem_o <= `OPDEC_RST_FLAG;
    end else begin
      byte_mem_o <= byte_mem_nxt;
    end
  end

  // Kind must name the field that the opcode carries
  // RQ2 registered pair select
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pair_sel_o <= opdec_pkg::OPDEC_PAIR_ZERO;
    end else begin
      pair_sel_o <= pair_sel_nxt;
    end
  end

  // RQ5 half routing register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pair_half_o <= `OPDEC_RST_HALF;
    end else begin
      pair_half_o <= pair_half_nxt;
    end
  end

  // RQ6 bit mask register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_mask_o <= `OPDEC_RST_MASK;
    end else begin
      bit_mask_o <= bit_mask_nxt;
    end
  end

  // Flags must be those in force for this opcode
  // RQ7 RQ8 condition register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cond_true_o <= `OPDEC_RST_FLAG;
    end else begin
      cond_true_o <= cond_true_nxt;
    end
  end

  // RQ9 restart target register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_addr_o <= `OPDEC_RST_ADDR;
    end else begin
      rst_addr_o <= rst_addr_nxt;
    end
  end
endmodule : opdec_top

// >>> include/opdec_defs.svh
// Purpose: Constants for the operand field decoder.
// Assumes: Field codes as laid out in the opcode.
// Notes: Definitions only.
`ifndef OPDEC_DEFS_SVH
`define OPDEC_DEFS_SVH
`define OPDEC_G_CODE_MEM 3'h6
`define OPDEC_P_CODE_ZERO 2'h0
`define OPDEC_P_CODE_ONE 2'h1
`define OPDEC_P_CODE_PTR 2'h2
`define OPDEC_P_CODE_TOP 2'h3
`define OPDEC_RST_SHIFT 3
`define OPDEC_FLAG_Z 1
`define OPDEC_FLAG_C 0
`define OPDEC_FLAG_PV 2
`define OPDEC_FLAG_S 7
`define OPDEC_HI_MSB 15
`define OPDEC_HI_LSB 8
`define OPDEC_LO_MSB 7
`define OPDEC_LO_LSB 0
`define OPDEC_RST_FLAG 1'h0
`define OPDEC_RST_HALF 8'h00
`define OPDEC_RST_MASK 8'h00
`define OPDEC_RST_ADDR 8'h00
`endif

// >>> include/opdec_pkg.sv
// Purpose: Types for the operand field decoder.
// Assumes: Nothing beyond the defs header.
// Notes: Encodings are the register file select codes.
package opdec_pkg;
  typedef enum logic [2:0] {
    OPDEC_BREG_B = 3'h0,
    OPDEC_BREG_C = 3'h1,
    OPDEC_BREG_D = 3'h2,
    OPDEC_BREG_E = 3'h3,
    OPDEC_BREG_PH = 3'h4,
    OPDEC_BREG_PL = 3'h5,
    OPDEC_BREG_NONE = 3'h6,
    OPDEC_BREG_ACC = 3'h7
  } opdec_breg_t;
  typedef enum logic [2:0] {
    OPDEC_PAIR_ZERO = 3'h0,
    OPDEC_PAIR_ONE = 3'h1,
    OPDEC_PAIR_MEMPTR = 3'h2,
    OPDEC_PAIR_STACK = 3'h3,
    OPDEC_PAIR_IDX1 = 3'h4,
    OPDEC_PAIR_IDX2 = 3'h5,
    OPDEC_PAIR_ACCF = 3'h6
  } opdec_pair_t;
  typedef enum logic [1:0] {
    OPDEC_KIND_GENERAL = 2'h0,
    OPDEC_KIND_IDX1 = 2'h1,
    OPDEC_KIND_IDX2 = 2'h2,
    OPDEC_KIND_STACKOP = 2'h3
  } opdec_kind_t;
endpackage : opdec_pkg

// >>> include/opdec_if.sv
// Purpose: Pair field request and answer between decoder modules.
// Assumes: Single clock domain.
// Notes: Combinational lookup.
`timescale 1ns/100ps
interface opdec_if;
  logic [1:0] code;
  opdec_pkg::opdec_kind_t kind;
  opdec_pkg::opdec_pair_t pair;
  modport requester (output code, output kind, input pair);
  modport decoder (input code, input kind, output pair);
endinterface : opdec_if

// >>> logic/opdec_pair.sv
// Purpose: Decode a two bit pair field to a pair select.
// Assumes: Field kind chosen by the opcode decode.
// Notes: Purely combinational.
`timescale 1ns/100ps
`include "opdec_defs.svh"
module opdec_pair (
  opdec_if.decoder pif
);
  always_comb begin
    case (pif.code)
      `OPDEC_P_CODE_ZERO: pif.pair = opdec_pkg::OPDEC_PAIR_ZERO;
      `OPDEC_P_CODE_ONE: pif.pair = opdec_pkg::OPDEC_PAIR_ONE;
      `OPDEC_P_CODE_PTR: begin
        // RQ3 index pair swap
        case (pif.kind)
          opdec_pkg::OPDEC_KIND_IDX1: pif.pair = opdec_pkg::OPDEC_PAIR_IDX1;
          opdec_pkg::OPDEC_KIND_IDX2: pif.pair = opdec_pkg::OPDEC_PAIR_IDX2;
          // RQ2 memory pointer pair
          default: pif.pair = opdec_pkg::OPDEC_PAIR_MEMPTR;
        endcase
      end
      default: begin
        // RQ4 stack op uses accumulator pair
        if (pif.kind == opdec_pkg::OPDEC_KIND_STACKOP) begin
          pif.pair = opdec_pkg::OPDEC_PAIR_ACCF;
        end else begin
          pif.pair = opdec_pkg::OPDEC_PAIR_STACK;
        end
      end
    endcase
  end
endmodule : opdec_pair

// >>> dv/opdec_regfile_model.sv
// Purpose: Register file side of the decoder.
// Assumes: Pair value and flags change at the falling edge.
// Notes: Random contents every cycle.
`timescale 1ns/100ps
module opdec_regfile_model (
  input wire logic clk_i,
  output logic [15:0] pair_value_o,
  output logic [7:0] flags_o
);
  initial begin
    {pair_value_o, flags_o} = '0;
    forever begin
      @(negedge clk_i);
      {pair_value_o, flags_o} <= 24'($urandom);
    end
  end
endmodule : opdec_regfile_model

// >>> dv/opdec_chk_sva.sv
// Purpose: port checks. Assumes: one cycle latency. Notes: bound below.
`timescale 1ns/100ps
module opdec_chk (
  input logic clk_i, nrst_i, half_high_i, byte_mem_o, cond_true_o,
  input logic [1:0] pair_code_i,
  input opdec_pkg::opdec_kind_t pair_kind_i,
  input logic [2:0] byte_code_i, bit_code_i, cond_code_i, rst_code_i,
  input opdec_pkg::opdec_breg_t byte_sel_o,
  input opdec_pkg::opdec_pair_t pair_sel_o,
  input logic [7:0] flags_i, pair_half_o, bit_mask_o, rst_addr_o,
  input logic [15:0] pair_value_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_byte; $past(nrst_i) |-> byte_sel_o == $past(byte_code_i)
    && byte_mem_o == ($past(byte_code_i) == 3'h6); endproperty
  a_byte: assert property (p_byte)
    else $error("byte");
  property p_mask; $past(nrst_i) |-> bit_mask_o == 8'h01 << $past(bit_code_i);
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask");
  property p_rst; $past(nrst_i) |->
    rst_addr_o == {2'h0, $past(rst_code_i), 3'h0}; endproperty
  a_rst: assert property (p_rst)
    else $error("rst");
  property p_half; $past(nrst_i) |-> pair_half_o ==
    $past(half_high_i ? pair_value_i[15:8] : pair_value_i[7:0]); endproperty
  a_half: assert property (p_half)
    else $error("half");
  property p_zc; $past(nrst_i && !cond_code_i[2]) |-> cond_true_o ==
    $past((cond_code_i[1] ? flags_i[0] : flags_i[1]) == cond_code_i[0]);
  endproperty
  a_zc: assert property (p_zc)
    else $error("zc");
  property p_ps; $past(nrst_i && cond_code_i[2]) |-> cond_true_o ==
    $past((cond_code_i[1] ? flags_i[7] : flags_i[2]) == cond_code_i[0]);
  endproperty
  a_ps: assert property (p_ps)
    else $error("ps");
  property p_pgen; $past(nrst_i && pair_code_i != 2'h2) |-> pair_sel_o ==
    $past(pair_kind_i == 2'h3 && pair_code_i == 2'h3 ? 3'h6
    : {1'b0, pair_code_i}); endproperty
  a_pgen: assert property (p_pgen)
    else $error("pgen");
  property p_pidx; $past(nrst_i && pair_code_i == 2'h2) |-> pair_sel_o ==
    $past(pair_kind_i == 2'h1 ? 3'h4 : pair_kind_i == 2'h2 ? 3'h5 : 3'h2);
  endproperty
  a_pidx: assert property (p_pidx)
    else $error("pidx");
endmodule : opdec_chk
bind opdec_top opdec_chk u_chk (.*);

// >>> dv/tb_top.sv
// Purpose: random self-check. Assumes: one cycle latency. Notes: queue.
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 0, nrst_i = 0, hh, bmem, ct;
  logic [2:0] bc, cc, tc, rc, bs, ps;
  logic [1:0] pc, pk;
  logic [15:0] pv;
  logic [7:0] fl, ph, bm, ra;
  logic [31:0] q[$];
  logic [31:0] e;
  int num_errors = 0, tests_run = 0;
  initial forever #25 clk_i = ~clk_i;
  opdec_regfile_model u_rf (.clk_i(clk_i), .pair_value_o(pv), .flags_o(fl));
  opdec_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .byte_code_i(bc),
    .pair_code_i(pc), .pair_kind_i(opdec_pkg::opdec_kind_t'(pk)),
    .pair_value_i(pv), .half_high_i(hh), .bit_code_i(tc), .cond_code_i(cc),
    .flags_i(fl), .rst_code_i(rc), .byte_sel_o(bs), .byte_mem_o(bmem),
    .pair_sel_o(ps), .pair_half_o(ph), .bit_mask_o(bm), .cond_true_o(ct),
    .rst_addr_o(ra));
  function automatic logic [31:0] model();
    logic [2:0] p;
    logic [3:0] f;
    p = {1'b0, pc};
    if (pc == 2'h2 && (pk == 2'h1 || pk == 2'h2)) p = 3'h3 + {1'b0, pk};
    if (pc == 2'h3 && pk == 2'h3) p = 3'h6;
    f = {fl[7], fl[2], fl[0], fl[1]};
    return {bc, bc == 3'h6, p, hh ? pv[15:8] : pv[7:0], 8'h01 << tc,
      f[cc[2:1]] == cc[0], 2'h0, rc, 3'h0};
  endfunction : model
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  initial forever begin
    @(posedge clk_i);
    #1 if (q.size() > 0) begin
      e = q.pop_front();
      check(32'(bs), 32'(e[31:29]));
      check(32'(bmem), 32'(e[28]));
      check(32'(ps), 32'(e[27:25]));
      check(32'(ph), 32'(e[24:17]));
      check(32'(bm), 32'(e[16:9]));
      check(32'(ct), 32'(e[8]));
      check(32'(ra), 32'(e[7:0]));
    end
  end
  initial begin
    {bc, pc, pk, hh, tc, cc, rc} = '0;
    void'($urandom(60845));
    repeat (6) @(posedge clk_i);
    @(negedge clk_i) nrst_i = 1;
    repeat (400) begin
      {bc, pc, pk, hh, tc, cc, rc} = 17'($urandom);
      #1 q.push_back(model());
      @(negedge clk_i);
    end
    for (int i = 0; i < 5 && q.size() > 0; i++) @(negedge clk_i);
    if (q.size() > 0) num_errors++;
    stop_test();
  end
endmodule : tb_top
